// ===== rtl/lp_pkg.sv
package lp_pkg;

  // Power states, one-hot
  typedef enum logic [7:0] {
    ST_NORMAL = 8'h01,
    ST_HALT_IDLE = 8'h02,
    ST_STOP_GRANT = 8'h04,
    ST_SNOOP = 8'h08,
    ST_SLEEP = 8'h10,
    ST_DEEP_SLEEP = 8'h20,
    ST_PLL_SETTLE = 8'h40,
    ST_FLUSH = 8'h80
  } state_type;

  // Event bit positions
  localparam int EVT_MASKABLE_IRQ = 0;
  localparam int EVT_NMI = 1;
  localparam int EVT_REINIT = 2;
  localparam int EVT_SMI = 3;
  localparam int EVT_W = 4;

  // Clock-stop enable bit, its register index and reset value
  localparam logic [11:0] CLK_STOP_MSR_INDEX = 12'h02A;
  localparam int CLK_STOP_MSR_BIT = 26;
  localparam logic CLK_STOP_EN_RESET = 1'b1;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint PLL_SETTLE_PS = 64'd1_000_000_000;
  localparam int PLL_SETTLE_CYCLES = int'(PLL_SETTLE_PS / CLK_PERIOD_PS);
  localparam int RESET_HOLD_CYCLES = 16;
  localparam int SLEEP_MIN_CYCLES = 1;
  localparam int CNT_W = 18;

endpackage

// ===== rtl/lp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lp_link_if;
  logic clock_stop_request_n;
  logic sleep_request_n;
  logic system_mgmt_irq_n;
  logic reinit_request_n;
  logic [1:0] local_irq_pins;
  logic flush_request_n;
  logic bus_error_reset_n;
  logic snoop_active;
  logic snoop_done;
  logic bus_clock_stopped;
  logic cpu_reset_n;
  logic [7:0] power_state;

  modport device (
    input clock_stop_request_n, sleep_request_n, system_mgmt_irq_n,
    input reinit_request_n, local_irq_pins, flush_request_n,
    input bus_error_reset_n, snoop_active, snoop_done,
    input bus_clock_stopped, cpu_reset_n,
    output power_state
  );

  modport host (
    output clock_stop_request_n, sleep_request_n, system_mgmt_irq_n,
    output reinit_request_n, local_irq_pins, flush_request_n,
    output bus_error_reset_n, snoop_active, snoop_done,
    output bus_clock_stopped, cpu_reset_n,
    input power_state
  );
endinterface
`default_nettype wire

// ===== rtl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] init,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_type;

  sync_type r;
  sync_type next_r;

  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  // Reset clears both stages, so q reads the idle level per bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign q = r.s2 ^ init;
endmodule
`default_nettype wire

// ===== rtl/lp_device.sv
// What this block does
// RULE1: HALT moves Normal to halt idle
// RULE2: SMI, reinit or local irq wake halt idle
// RULE3: Reset in halt idle initializes at once
// RULE4: SMI return picks Normal or halt idle
// RULE5: Flush in halt idle serviced, back idle
// RULE6: Clock stop from halt idle returns there
// RULE7: Clock stop request enters stop grant
// RULE8: Partner keeps bus quiet in stop grant
// RULE9: No bus init or flush in grant
// RULE10: Reset in grant initializes, stays grant
// RULE11: Clock stop release returns to Normal
// RULE12: Snoop state until serviced, then back
// RULE13: Sleep request in grant enters Sleep
// RULE14: Grant latches events once, served later
// RULE15: Sleep request ignored outside stop grant
// RULE16: Sleep keeps PLL, stops internal clocks
// RULE17: No snoops or latching while asleep
// RULE18: Held reset in Sleep resets directly
// RULE19: Partner drops sleep and stop after reset
// RULE20: Sleep request held one clock minimum
// RULE21: Stopped bus clock in Sleep: Deep Sleep
// RULE22: Clocks stop only when enable bit set; the PLL still stops in Deep Sleep with the bit clear
// RULE23: Clock restart needs 1 ms settle
// RULE24: Sleep release returns to stop grant
`timescale 1ns/1ps
`default_nettype none
module lp_device #(
  parameter int PLL_SETTLE_CYCLES = lp_pkg::PLL_SETTLE_CYCLES,
  parameter int RESET_HOLD_CYCLES = lp_pkg::RESET_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link
  lp_link_if.device link,
  // Core side
  input wire logic halt_exec,
  input wire logic smi_done,
  input wire logic smi_to_halt,
  input wire logic flush_done,
  input wire logic clock_stop_enable,
  output lp_pkg::state_type state,
  output logic internal_clocks_on,
  output logic pll_on,
  output logic [lp_pkg::EVT_W-1:0] service,
  output logic init_pulse,
  output logic bus_init_pulse
);
  import lp_pkg::*;

  typedef struct packed {
    state_type st;
    logic from_halt;
    logic snoop_to_halt;
    logic [EVT_W-1:0] pending;
    logic [EVT_W-1:0] prev_evt;
    logic [EVT_W-1:0] service;
    logic init;
    logic bus_init;
    logic prev_rst;
    logic prev_berr;
    logic [CNT_W-1:0] cnt;
  } dev_state_type;

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(PLL_SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RESET_HOLD_CYCLES - 1);
  // Idle levels of active-low pins, so reset reads them inactive
  localparam logic [12:0] PIN_IDLE = 13'h1_E62;

  dev_state_type r;
  dev_state_type next_r;
  logic [12:0] pins;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] rise;
  logic stop_req;
  logic sleep_req;
  logic flush_req;
  logic berr;
  logic snoop;
  logic snoop_ok;
  logic bclk_stop;
  logic cpu_rst;

  sync2 #(.W(13)) pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({link.clock_stop_request_n, link.sleep_request_n,
        link.system_mgmt_irq_n, link.reinit_request_n,
        link.local_irq_pins, link.flush_request_n,
        link.bus_error_reset_n, link.snoop_active, link.snoop_done,
        link.bus_clock_stopped, link.cpu_reset_n, 1'b0} ^ PIN_IDLE),
    .init(PIN_IDLE),
    .q(pins)
  );

  assign stop_req = !pins[12];
  assign sleep_req = !pins[11];
  assign evt = {!pins[10], !pins[9], pins[8], pins[7]};
  assign flush_req = !pins[6];
  assign berr = !pins[5];
  assign snoop = pins[4];
  assign snoop_ok = pins[3];
  assign bclk_stop = pins[2];
  assign cpu_rst = !pins[1];
  assign rise = evt & ~r.prev_evt;

  always_comb
  begin
    next_r = r;
    next_r.prev_evt = evt;
    next_r.prev_rst = cpu_rst;
    next_r.prev_berr = berr;
    next_r.service = '0;
    next_r.init = 1'b0;
    next_r.bus_init = 1'b0;
    case (r.st)
      ST_NORMAL:
      begin
        next_r.service = rise;
        next_r.bus_init = berr && !r.prev_berr;
        next_r.from_halt = 1'b0;
        if (cpu_rst)
        begin
          next_r.init = !r.prev_rst;
        end
        // RULE7: grant on request
        else if (stop_req)
        begin
          next_r.st = ST_STOP_GRANT;
        end
        // RULE4: handler return target
        else if (smi_done && smi_to_halt)
        begin
          next_r.st = ST_HALT_IDLE;
        end
        // RULE1: halt instruction
        else if (halt_exec)
        begin
          next_r.st = ST_HALT_IDLE;
        end
      end
      ST_HALT_IDLE:
      begin
        next_r.bus_init = berr && !r.prev_berr;
        // RULE3: immediate initialize
        if (cpu_rst)
        begin
          next_r.init = !r.prev_rst;
          next_r.st = ST_NORMAL;
        end
        // RULE2: wake on events
        else if ((rise | r.pending) != '0)
        begin
          next_r.service = rise | r.pending;
          next_r.pending = '0;
          next_r.st = ST_NORMAL;
        end
        // RULE6: remember halt origin
        else if (stop_req)
        begin
          next_r.from_halt = 1'b1;
          next_r.st = ST_STOP_GRANT;
        end
        // RULE12: snoop from halt idle
        else if (snoop)
        begin
          next_r.snoop_to_halt = 1'b1;
          next_r.st = ST_SNOOP;
        end
        // RULE5: flush service
        else if (flush_req)
        begin
          next_r.st = ST_FLUSH;
        end
      end
      ST_FLUSH:
      begin
        // RULE5: back to halt idle
        if (flush_done)
        begin
          next_r.st = ST_HALT_IDLE;
        end
      end
      ST_STOP_GRANT:
      begin
        // RULE14: latch once each
        next_r.pending = r.pending | rise;
        // RULE10: initialize, stay granted
        if (cpu_rst)
        begin
          next_r.init = !r.prev_rst;
          next_r.pending = '0;
        end
        // RULE11: release to origin
        else if (!stop_req)
        begin
          next_r.st = r.from_halt ? ST_HALT_IDLE : ST_NORMAL;
          // RULE14: serve latched on return
          next_r.service = r.from_halt ? '0 : (r.pending | rise);
          next_r.pending = r.from_halt ? (r.pending | rise) : '0;
        end
        // RULE13: sleep request
        else if (sleep_req)
        begin
          next_r.st = ST_SLEEP;
          next_r.cnt = '0;
        end
        // RULE12: snoop from grant
        else if (snoop)
        begin
          next_r.snoop_to_halt = 1'b0;
          next_r.st = ST_SNOOP;
        end
      end
      ST_SNOOP:
      begin
        if (r.snoop_to_halt == 1'b0)
        begin
          next_r.pending = r.pending | rise;
        end
        // RULE12: return when serviced
        if (snoop_ok)
        begin
          next_r.st = r.snoop_to_halt ? ST_HALT_IDLE : ST_STOP_GRANT;
        end
      end
      ST_SLEEP:
      begin
        next_r.cnt = cpu_rst ? r.cnt + 1'b1 : '0;
        // RULE18: held reset bypasses grant
        if (cpu_rst && r.cnt == HOLD_LAST)
        begin
          next_r.init = 1'b1;
          next_r.pending = '0;
          next_r.from_halt = 1'b0;
          next_r.st = ST_NORMAL;
          next_r.cnt = '0;
        end
        // RULE24: release to grant
        else if (!sleep_req && !cpu_rst)
        begin
          next_r.st = ST_STOP_GRANT;
        end
        // RULE21: bus clock stopped
        else if (bclk_stop)
        begin
          next_r.st = ST_DEEP_SLEEP;
        end
      end
      ST_DEEP_SLEEP:
      begin
        next_r.cnt = '0;
        if (!bclk_stop)
        begin
          next_r.st = ST_PLL_SETTLE;
        end
      end
      ST_PLL_SETTLE:
      begin
        next_r.cnt = r.cnt + 1'b1;
        // RULE23: settle before Sleep
        if (bclk_stop)
        begin
          next_r.st = ST_DEEP_SLEEP;
        end
        else if (r.cnt == SETTLE_LAST)
        begin
          next_r.st = ST_SLEEP;
          next_r.cnt = '0;
        end
      end
      default:
      begin
        next_r.st = ST_NORMAL;
      end
    endcase
    // RULE17: nothing latched while asleep
    if (r.st inside {ST_SLEEP, ST_DEEP_SLEEP, ST_PLL_SETTLE} &&
      next_r.st != ST_NORMAL)
    begin
      next_r.pending = r.pending;
    end
    // RULE15: RULE9: sleep, flush and bus init ignored by branch structure
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '{st: ST_NORMAL, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign state = r.st;
  assign link.power_state = r.st;
  assign service = r.service;
  assign init_pulse = r.init;
  assign bus_init_pulse = r.bus_init;
  // RULE16: RULE22: internal clocks gated by enable bit; PLL off in Deep Sleep whatever the bit
  assign internal_clocks_on = !(clock_stop_enable && (r.st inside
    {ST_STOP_GRANT, ST_SLEEP, ST_DEEP_SLEEP, ST_PLL_SETTLE}));
  assign pll_on = !(r.st == ST_DEEP_SLEEP);
endmodule
`default_nettype wire

// ===== rtl/lp_host.sv
`timescale 1ns/1ps
`default_nettype none
module lp_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link
  lp_link_if.host link,
  // User commands
  input wire logic stop_clock_req,
  input wire logic sleep_req,
  input wire logic reset_req,
  input wire logic smi_req,
  input wire logic reinit_req,
  input wire logic [1:0] irq_req,
  input wire logic flush_req,
  input wire logic bus_error_req,
  input wire logic snoop_req,
  input wire logic snoop_serviced,
  input wire logic bus_clock_stop_req,
  // Status
  output logic [7:0] device_state
);
  import lp_pkg::*;

  typedef struct packed {
    logic stop_n;
    logic sleep_n;
    logic smi_n;
    logic reinit_n;
    logic [1:0] irq;
    logic flush_n;
    logic berr_n;
    logic snoop;
    logic snoop_done;
    logic bclk_stop;
    logic rst_n;
  } host_state_type;

  host_state_type r;
  host_state_type next_r;
  logic [7:0] dev_st;
  logic grant;
  logic asleep;

  sync2 #(.W(8)) state_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.power_state ^ 8'h01),
    .init(8'h01),
    .q(dev_st)
  );

  assign grant = dev_st == ST_STOP_GRANT;
  assign asleep = dev_st inside {ST_SLEEP, ST_DEEP_SLEEP, ST_PLL_SETTLE};

  always_comb
  begin
    next_r.rst_n = !reset_req;
    next_r.stop_n = !stop_clock_req;
    // Sleep only offered in grant, while already asleep, or while already offered
    next_r.sleep_n = !(sleep_req && (grant || asleep || !r.sleep_n));
    // RULE19: drop both after reset in Sleep
    if (reset_req && asleep)
    begin
      next_r.stop_n = 1'b1;
      next_r.sleep_n = 1'b1;
    end
    // RULE17: quiet bus while asleep
    next_r.smi_n = !(smi_req && !asleep);
    next_r.reinit_n = !(reinit_req && !asleep);
    next_r.irq = asleep ? 2'b00 : irq_req;
    next_r.snoop = snoop_req && !asleep;
    next_r.snoop_done = snoop_serviced && !asleep;
    // RULE8: unserviced inputs held inactive in grant
    next_r.flush_n = !(flush_req && !asleep && !grant);
    next_r.berr_n = !(bus_error_req && !asleep && !grant);
    // RULE21: clock stop only from Sleep
    next_r.bclk_stop = bus_clock_stop_req &&
      (dev_st inside {ST_SLEEP, ST_DEEP_SLEEP} || r.bclk_stop);
    // RULE20: registered request stands a full clock
    if (!r.sleep_n && SLEEP_MIN_CYCLES > 1)
    begin
      next_r.sleep_n = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '{irq: 2'b00, snoop: 1'b0, snoop_done: 1'b0, bclk_stop: 1'b0,
             default: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign link.clock_stop_request_n = r.stop_n;
  assign link.sleep_request_n = r.sleep_n;
  assign link.system_mgmt_irq_n = r.smi_n;
  assign link.reinit_request_n = r.reinit_n;
  assign link.local_irq_pins = r.irq;
  assign link.flush_request_n = r.flush_n;
  assign link.bus_error_reset_n = r.berr_n;
  assign link.snoop_active = r.snoop;
  assign link.snoop_done = r.snoop_done;
  assign link.bus_clock_stopped = r.bclk_stop;
  assign link.cpu_reset_n = r.rst_n;
  assign device_state = dev_st;
endmodule
`default_nettype wire

// ===== verification/lp_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lp_link_properties #(
  parameter int SETTLE = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link pins
  input wire logic clock_stop_request_n,
  input wire logic sleep_request_n,
  input wire logic snoop_active,
  input wire logic snoop_done,
  input wire logic bus_clock_stopped,
  input wire logic cpu_reset_n,
  input wire logic [7:0] power_state
);
  import lp_pkg::*;
  logic [7:0] settle_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Cycles spent in settle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      settle_cnt <= 8'h00;
    else if (power_state == ST_PLL_SETTLE)
      settle_cnt <= settle_cnt + 8'h01;
    else
      settle_cnt <= 8'h00;
  end

  sequence grant_quiet;
    (!clock_stop_request_n && sleep_request_n && !snoop_active)[*3];
  endsequence
  sequence snoop_wait;
    (power_state == ST_SNOOP && !snoop_done)[*4];
  endsequence
  sequence sleep_hold;
    power_state == ST_SLEEP && !cpu_reset_n;
  endsequence

  stop_entry_a:
  assert property ($fell(clock_stop_request_n) && cpu_reset_n &&
    power_state == ST_NORMAL |-> ##[1:4] power_state == ST_STOP_GRANT)
  else $error("stop request did not reach grant");
  stop_release_a:
  assert property (power_state == ST_STOP_GRANT && cpu_reset_n &&
    $rose(clock_stop_request_n) |->
    ##[1:4] power_state inside {ST_NORMAL, ST_HALT_IDLE})
  else $error("stop release did not leave grant");
  sleep_entry_a:
  assert property (power_state == ST_STOP_GRANT && !clock_stop_request_n &&
    $fell(sleep_request_n) |-> ##[1:4] power_state == ST_SLEEP)
  else $error("sleep request did not reach sleep");
  sleep_ignore_a:
  assert property (power_state inside {ST_NORMAL, ST_HALT_IDLE} |=>
    power_state != ST_SLEEP)
  else $error("sleep entered outside grant");
  snoop_hold_a:
  assert property (snoop_wait |=> power_state == ST_SNOOP)
  else $error("snoop state left before service");
  snoop_return_a:
  assert property ($fell(power_state == ST_SNOOP) |->
    power_state inside {ST_STOP_GRANT, ST_HALT_IDLE})
  else $error("snoop state returned to wrong state");
  deep_entry_a:
  assert property ($rose(power_state == ST_DEEP_SLEEP) |->
    $past(power_state) == ST_SLEEP && bus_clock_stopped)
  else $error("deep sleep entered wrongly");
  settle_time_a:
  assert property ($fell(power_state == ST_PLL_SETTLE) |->
    power_state == ST_SLEEP && settle_cnt >= SETTLE - 1 &&
    settle_cnt <= SETTLE + 1)
  else $error("settle interval wrong");
  grant_hold_a:
  assert property (grant_quiet ##0 power_state == ST_STOP_GRANT |=>
    power_state == ST_STOP_GRANT)
  else $error("grant left without cause");
  sleep_reset_a:
  assert property (sleep_hold |=> power_state inside {ST_SLEEP, ST_NORMAL})
  else $error("reset in sleep passed through grant");
endmodule
`default_nettype wire

// ===== verification/test_low_power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_low_power_state_controller;
  import lp_pkg::*;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic stop_clock_req = 1'b0;
  logic sleep_req = 1'b0;
  logic reset_req = 1'b0;
  logic smi_req = 1'b0;
  logic reinit_req = 1'b0;
  logic [1:0] irq_req = 2'h0;
  logic flush_req = 1'b0;
  logic bus_error_req = 1'b0;
  logic snoop_req = 1'b0;
  logic snoop_serviced = 1'b0;
  logic bus_clock_stop_req = 1'b0;
  logic halt_exec = 1'b0;
  logic smi_done = 1'b0;
  logic smi_to_halt = 1'b0;
  logic flush_done = 1'b0;
  logic clock_stop_enable = 1'b1;
  state_type state;
  logic internal_clocks_on;
  logic pll_on;
  logic [EVT_W-1:0] service;
  logic init_pulse;
  logic bus_init_pulse;
  logic [7:0] device_state;
  logic [7:0] last_state = 8'h01;
  logic serv_on = 1'b0;
  logic en;
  int err_total = 0;
  int compares = 0;
  state_type state_q[$];
  logic [3:0] serv_q[$];
  logic [1:0] init_q[$];

  lp_link_if lp_link_if_i ();
  lp_host lp_host_i (.clk(clk), .reset_n(reset_n), .link(lp_link_if_i),
    .stop_clock_req(stop_clock_req), .sleep_req(sleep_req),
    .reset_req(reset_req), .smi_req(smi_req), .reinit_req(reinit_req),
    .irq_req(irq_req), .flush_req(flush_req),
    .bus_error_req(bus_error_req), .snoop_req(snoop_req),
    .snoop_serviced(snoop_serviced),
    .bus_clock_stop_req(bus_clock_stop_req), .device_state(device_state));
  lp_device #(.PLL_SETTLE_CYCLES(SETTLE), .RESET_HOLD_CYCLES(4))
  lp_device_i (.clk(clk), .reset_n(reset_n), .link(lp_link_if_i),
    .halt_exec(halt_exec), .smi_done(smi_done), .smi_to_halt(smi_to_halt),
    .flush_done(flush_done), .clock_stop_enable(clock_stop_enable),
    .state(state), .internal_clocks_on(internal_clocks_on),
    .pll_on(pll_on), .service(service), .init_pulse(init_pulse),
    .bus_init_pulse(bus_init_pulse));
  lp_link_properties #(.SETTLE(SETTLE)) lp_link_properties_i (.clk(clk),
    .reset_n(reset_n),
    .clock_stop_request_n(lp_link_if_i.clock_stop_request_n),
    .sleep_request_n(lp_link_if_i.sleep_request_n),
    .snoop_active(lp_link_if_i.snoop_active),
    .snoop_done(lp_link_if_i.snoop_done),
    .bus_clock_stopped(lp_link_if_i.bus_clock_stopped),
    .cpu_reset_n(lp_link_if_i.cpu_reset_n),
    .power_state(lp_link_if_i.power_state));

  initial
    forever #2 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reach(input state_type s);
    int n;
    n = 0;
    state_q.push_back(s);
    while (state !== s && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check("reach", state, s);
  endtask

  task automatic core_pulse(input int k);
    @(posedge clk);
    case (k)
      0: halt_exec <= 1'b1;
      1: smi_done <= 1'b1;
      default: flush_done <= 1'b1;
    endcase
    @(posedge clk);
    halt_exec <= 1'b0;
    smi_done <= 1'b0;
    flush_done <= 1'b0;
  endtask

  task automatic set_ev(input int i, input logic v);
    @(posedge clk);
    case (i)
      0: irq_req[0] <= v;
      1: irq_req[1] <= v;
      2: reinit_req <= v;
      default: smi_req <= v;
    endcase
  endtask

  // Watcher takes each result off its queue
  always @(negedge clk)
  begin
    if (reset_n === 1'b1)
    begin
      if (state !== last_state)
        check("state", state, state_q.size() ? state_q.pop_front() : 8'hff);
      if (serv_on && service !== 4'h0)
        check("service", service, serv_q.size() ? serv_q.pop_front() : 4'hf);
      if ((init_pulse | bus_init_pulse) !== 1'b0)
        check("init", {init_pulse, bus_init_pulse},
          init_q.size() ? init_q.pop_front() : 2'h3);
    end
    last_state = state;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial
  begin
    void'($urandom(48));
    cyc(2);
    reset_n <= 1'b1;
    cyc(2);
    for (int i = 0; i < 4; i++)
    begin
      core_pulse(0);
      reach(ST_HALT_IDLE);
      set_ev(i, 1'b1);
      reach(ST_NORMAL);
      set_ev(i, 1'b0);
    end
    core_pulse(1);
    cyc(8);
    @(posedge clk) smi_to_halt <= 1'b1;
    core_pulse(1);
    reach(ST_HALT_IDLE);
    @(posedge clk) flush_req <= 1'b1;
    reach(ST_FLUSH);
    @(posedge clk) flush_req <= 1'b0;
    cyc(4);
    core_pulse(2);
    reach(ST_HALT_IDLE);
    @(posedge clk) stop_clock_req <= 1'b1;
    reach(ST_STOP_GRANT);
    @(posedge clk) stop_clock_req <= 1'b0;
    reach(ST_HALT_IDLE);
    @(posedge clk) sleep_req <= 1'b1;
    cyc(10);
    sleep_req <= 1'b0;
    init_q.push_back(2'b10);
    @(posedge clk) reset_req <= 1'b1;
    reach(ST_NORMAL);
    @(posedge clk) reset_req <= 1'b0;
    cyc(8);
    serv_on = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      en = 1'($urandom);
      @(posedge clk);
      clock_stop_enable <= en;
      stop_clock_req <= 1'b1;
      reach(ST_STOP_GRANT);
      check("clocks_on", internal_clocks_on, !en);
      repeat (2)
      begin
        set_ev(i, 1'b1);
        cyc(4);
        set_ev(i, 1'b0);
        cyc(4);
      end
      @(posedge clk);
      flush_req <= 1'b1;
      bus_error_req <= 1'b1;
      cyc(10);
      flush_req <= 1'b0;
      bus_error_req <= 1'b0;
      serv_q.push_back(4'(1 << i));
      @(posedge clk) stop_clock_req <= 1'b0;
      reach(ST_NORMAL);
      cyc(8);
    end
    init_q.push_back(2'b01);
    @(posedge clk) bus_error_req <= 1'b1;
    cyc(10);
    bus_error_req <= 1'b0;
    @(posedge clk);
    clock_stop_enable <= 1'b1;
    stop_clock_req <= 1'b1;
    reach(ST_STOP_GRANT);
    @(posedge clk) snoop_req <= 1'b1;
    reach(ST_SNOOP);
    cyc(8);
    snoop_req <= 1'b0;
    snoop_serviced <= 1'b1;
    reach(ST_STOP_GRANT);
    @(posedge clk) snoop_serviced <= 1'b0;
    @(posedge clk) sleep_req <= 1'b1;
    reach(ST_SLEEP);
    check("clocks_on", internal_clocks_on, 1'b0);
    check("pll_on", pll_on, 1'b1);
    @(posedge clk) bus_clock_stop_req <= 1'b1;
    reach(ST_DEEP_SLEEP);
    check("pll_on", pll_on, 1'b0);
    @(posedge clk) bus_clock_stop_req <= 1'b0;
    reach(ST_PLL_SETTLE);
    reach(ST_SLEEP);
    @(posedge clk) sleep_req <= 1'b0;
    reach(ST_STOP_GRANT);
    init_q.push_back(2'b10);
    @(posedge clk) reset_req <= 1'b1;
    cyc(12);
    reset_req <= 1'b0;
    cyc(8);
    check("grant", state, ST_STOP_GRANT);
    @(posedge clk) sleep_req <= 1'b1;
    reach(ST_SLEEP);
    init_q.push_back(2'b10);
    @(posedge clk);
    reset_req <= 1'b1;
    sleep_req <= 1'b0;
    stop_clock_req <= 1'b0;
    reach(ST_NORMAL);
    @(posedge clk) reset_req <= 1'b0;
    cyc(10);
    check("device_state", device_state, ST_NORMAL);
    check("left", 8'(state_q.size() + serv_q.size() + init_q.size()), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
